// ---- logic/tps_pkg.sv ----
/*
  Constants of the test register page: register indices, field positions,
  reset values, writable masks, selector codes and bus answer codes.
  Assumes one 32-bit register word per index, byte address = index * 4.
*/
package tps_pkg;
  // Register indices; byte address is the index times four
  localparam logic [7:0] IDX_RSVD     = 8'h30;
  localparam logic [7:0] IDX_BIT_SEL  = 8'h31;
  localparam logic [7:0] IDX_BUS_CTRL = 8'h32;
  localparam logic [7:0] IDX_PIN_EN   = 8'h33;
  localparam logic [7:0] IDX_PIN_VAL  = 8'h34;
  localparam logic [7:0] IDX_READBACK = 8'h35;
  localparam logic [7:0] IDX_AUX_SEL  = 8'h38;

  localparam int ADDR_W = 10;

  // Reset values
  localparam logic [7:0] RST_BIT_SEL  = 8'h00;
  localparam logic [7:0] RST_BUS_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_EN   = 8'h80;
  localparam logic [7:0] RST_PIN_VAL  = 8'h00;
  localparam logic [7:0] RST_AUX_SEL  = 8'h00;

  // Writable bits; reserved bits stay zero
  localparam logic [7:0] MASK_BIT_SEL  = 8'h07;
  localparam logic [7:0] MASK_BUS_CTRL = 8'hFF;
  localparam logic [7:0] MASK_PIN_EN   = 8'hFE;
  localparam logic [7:0] MASK_PIN_VAL  = 8'hFE;
  localparam logic [7:0] MASK_AUX_SEL  = 8'hFF;

  // Field positions
  localparam int BIT_CHOICE_MSB = 2;
  localparam int ORDER_SWAP_BIT = 7;
  localparam int PRBS9_BIT      = 6;
  localparam int PRBS15_BIT     = 5;
  localparam int GROUP_MSB      = 4;
  localparam int SERIAL_EN_BIT  = 7;
  localparam int PIN_LSB        = 1;
  localparam int PIN_MSB        = 6;
  localparam int IO_MODE_BIT    = 7;
  localparam int AUX_PIN_ONE_LSB       = 4;
  localparam int AUX_PIN_TWO_LSB       = 0;

  localparam int GROUPS = 32;

  // Aux pin selector codes handled digitally
  localparam logic [3:0] AUX_TRISTATE = 4'h0;
  localparam logic [3:0] AUX_HIGH     = 4'hA;
  localparam logic [3:0] AUX_LOW      = 4'hB;
  localparam logic [3:0] AUX_TEST_BIT = 4'hF;

  // Swapped test bus order, D4 first
  localparam logic [17:0] SWAP_MAP = {3'd0, 3'd5, 3'd6, 3'd2, 3'd3, 3'd4};

  // Pattern generator taps (bit positions of the shift register)
  localparam int PRBS9_TAP_A  = 8;
  localparam int PRBS9_TAP_B  = 4;
  localparam int PRBS15_TAP_A = 14;
  localparam int PRBS15_TAP_B = 13;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {
    PAT_IDLE = 1'b0,
    PAT_RUN  = 1'b1
  } tps_pat_state_type;
endpackage

// ---- logic/tps_test_page.sv ----
/*
  Test register page: test bus selection and readback, multipurpose and aux
  pin test outputs, pattern generator control and the spare data pin port.
  Assumes an AXI4-Lite master on clk, probe groups from logic on clk, and
  data pin levels arriving asynchronously from the package pins.
*/
// Design decision made here: the AXI4-Lite register port.

// Functional notes
// - Chosen test bus bit drives multipurpose pin
// - Aux test-bus code also drives aux pin
// - Aux code 1111 outputs chosen bus bit
// - Swap bit reorders bus bits 4,3,2,6,5,0
// - Bit 6 enables nine-stage pattern
// - Bit 5 enables fifteen-stage pattern when bit 6 clear
// - Pattern starts only on transmit command
// - Group field selects signals on probe bus
// - Serial line enable gates UART lines
// - Enable bit n drives data pin n
// - I/O mode with serial host: general port
// - Enabled pins drive stored levels in I/O
// - Pin value read shows live pins in I/O
// - Readback returns current eight-bit probe bus
// - Slot 30h and reserved bits read zero
module tps_test_page (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [tps_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [tps_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [8*tps_pkg::GROUPS-1:0] probe_groups,
  input  wire logic                        serial_host_active,
  input  wire logic                        transmit_cmd,
  input  wire logic                        tx_bit_tick,
  input  wire logic [6:1]                  data_pin_in,
  output logic [6:1]                       data_pin_out,
  output logic [6:1]                       data_pin_oe,
  output logic                             multipurpose_out_pin,
  output logic                             aux_pin_one_out,
  output logic                             aux_pin_one_oe,
  output logic                             aux_pin_two_out,
  output logic                             aux_pin_two_oe,
  output logic                             uart_aux_out_en,
  output logic                             uart_request_line_en,
  output logic                             prbs_tx_data,
  output logic                             prbs_tx_active
);
  logic [7:0]                     bit_sel_q;
  logic [7:0]                     bus_ctrl_q;
  logic [7:0]                     pin_en_q;
  logic [7:0]                     pin_val_q;
  logic [7:0]                     aux_sel_q;
  logic [7:0]                     probe_q;
  logic [6:1]                     pin_meta_q;
  logic [6:1]                     pin_sync_q;
  logic                           aw_held_q;
  logic                           w_held_q;
  logic [7:0]                     aw_idx_q;
  logic [7:0]                     w_data_q;
  logic                           w_lane_q;
  logic [14:0]                    lfsr_q;
  tps_pkg::tps_pat_state_type     pat_q;
  tps_pkg::tps_pat_state_type     pat_d;
  logic                           do_write;
  logic                           wr_known;
  logic [7:0]                     rd_val;
  logic                           rd_known;
  logic [2:0]                     bit_choice;
  logic                           chosen_bit;
  logic                           io_active;
  logic [6:1]                     test_sig;
  logic                           prbs9_on;
  logic                           prbs15_on;
  logic                           fb;

  // Write channel: address and data taken in either order
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_comb begin
    case (aw_idx_q)
      tps_pkg::IDX_RSVD,
      tps_pkg::IDX_BIT_SEL,
      tps_pkg::IDX_BUS_CTRL,
      tps_pkg::IDX_PIN_EN,
      tps_pkg::IDX_PIN_VAL,
      tps_pkg::IDX_READBACK,
      tps_pkg::IDX_AUX_SEL: wr_known = 1'b1;
      default:              wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_q     <= 1'b0;
      aw_idx_q      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q     <= 1'b1;
      aw_idx_q      <= s_axi_awaddr[tps_pkg::ADDR_W-1:2];
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held_q     <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q     <= 1'b1;
      w_data_q     <= s_axi_wdata[7:0];
      w_lane_q     <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held_q     <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tps_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_known ? tps_pkg::RESP_OKAY : tps_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register storage; only writable bits take the written value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_sel_q  <= tps_pkg::RST_BIT_SEL;
      bus_ctrl_q <= tps_pkg::RST_BUS_CTRL;
      pin_en_q   <= tps_pkg::RST_PIN_EN;
      pin_val_q  <= tps_pkg::RST_PIN_VAL;
      aux_sel_q  <= tps_pkg::RST_AUX_SEL;
    end else if (do_write && w_lane_q) begin
      case (aw_idx_q)
        tps_pkg::IDX_BIT_SEL:  bit_sel_q  <= w_data_q & tps_pkg::MASK_BIT_SEL;
        tps_pkg::IDX_BUS_CTRL: bus_ctrl_q <= w_data_q & tps_pkg::MASK_BUS_CTRL;
        tps_pkg::IDX_PIN_EN:   pin_en_q   <= w_data_q & tps_pkg::MASK_PIN_EN;
        tps_pkg::IDX_PIN_VAL:  pin_val_q  <= w_data_q & tps_pkg::MASK_PIN_VAL;
        tps_pkg::IDX_AUX_SEL:  aux_sel_q  <= w_data_q & tps_pkg::MASK_AUX_SEL;
        default: ;  // Reserved slot and readback keep no state
      endcase
    end
  end

  // Pin levels synchronised before any use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= data_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Probe bus: group chosen by the group field
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      probe_q <= 8'h00;
    end else begin
      probe_q <= probe_groups[bus_ctrl_q[tps_pkg::GROUP_MSB:0]*8 +: 8];
    end
  end

  // Read channel
  assign io_active = pin_val_q[tps_pkg::IO_MODE_BIT] && serial_host_active;

  always_comb begin
    rd_val   = 8'h00;
    rd_known = 1'b1;
    case (s_axi_araddr[tps_pkg::ADDR_W-1:2])
      tps_pkg::IDX_RSVD:     rd_val = 8'h00;
      tps_pkg::IDX_BIT_SEL:  rd_val = bit_sel_q;
      tps_pkg::IDX_BUS_CTRL: rd_val = bus_ctrl_q;
      tps_pkg::IDX_PIN_EN:   rd_val = pin_en_q;
      tps_pkg::IDX_PIN_VAL: begin
        if (pin_val_q[tps_pkg::IO_MODE_BIT]) begin
          rd_val = {pin_val_q[tps_pkg::IO_MODE_BIT], pin_sync_q, 1'b0};
        end else begin
          rd_val = pin_val_q;
        end
      end
      tps_pkg::IDX_READBACK: rd_val = probe_q;
      tps_pkg::IDX_AUX_SEL:  rd_val = aux_sel_q;
      default:               rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_val};
      s_axi_rresp   <= rd_known ? tps_pkg::RESP_OKAY : tps_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= !s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Test signal per data pin, natural or swapped order
  genvar gi;
  generate
    for (gi = 1; gi <= 6; gi++) begin : g_pin_map
      always_comb begin
        if (bus_ctrl_q[tps_pkg::ORDER_SWAP_BIT]) begin
          test_sig[gi] = probe_q[tps_pkg::SWAP_MAP[(gi-1)*3 +: 3]];
        end else begin
          test_sig[gi] = probe_q[gi];
        end
      end
    end
  endgenerate

  // Data pin drivers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_pin_out <= '0;
      data_pin_oe  <= '0;
    end else begin
      data_pin_oe <= pin_en_q[tps_pkg::PIN_MSB:tps_pkg::PIN_LSB];
      if (io_active) begin
        data_pin_out <= pin_val_q[tps_pkg::PIN_MSB:tps_pkg::PIN_LSB];
      end else begin
        data_pin_out <= test_sig;
      end
    end
  end

  // Multipurpose and aux pins
  assign bit_choice = bit_sel_q[tps_pkg::BIT_CHOICE_MSB:0];
  assign chosen_bit = probe_q[bit_choice];

  function automatic logic [1:0] aux_drive(input logic [3:0] code, input logic tb);
    case (code)
      tps_pkg::AUX_TEST_BIT: aux_drive = {1'b1, tb};
      tps_pkg::AUX_HIGH:     aux_drive = 2'b11;
      tps_pkg::AUX_LOW:      aux_drive = 2'b10;
      default:               aux_drive = 2'b00;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multipurpose_out_pin <= 1'b0;
      aux_pin_one_oe       <= 1'b0;
      aux_pin_one_out      <= 1'b0;
      aux_pin_two_oe       <= 1'b0;
      aux_pin_two_out      <= 1'b0;
    end else begin
      multipurpose_out_pin <= chosen_bit;
      {aux_pin_one_oe, aux_pin_one_out} <= aux_drive(aux_sel_q[tps_pkg::AUX_PIN_ONE_LSB +: 4],
                                                     chosen_bit);
      {aux_pin_two_oe, aux_pin_two_out} <= aux_drive(aux_sel_q[tps_pkg::AUX_PIN_TWO_LSB +: 4],
                                                     chosen_bit);
    end
  end

  // Serial line gating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uart_aux_out_en      <= 1'b1;
      uart_request_line_en <= 1'b1;
    end else begin
      uart_aux_out_en      <= pin_en_q[tps_pkg::SERIAL_EN_BIT];
      uart_request_line_en <= pin_en_q[tps_pkg::SERIAL_EN_BIT];
    end
  end

  // Pattern generator; host has set up transmission beforehand
  assign prbs9_on  = bus_ctrl_q[tps_pkg::PRBS9_BIT];
  assign prbs15_on = bus_ctrl_q[tps_pkg::PRBS15_BIT];
  assign fb = prbs9_on ? (lfsr_q[tps_pkg::PRBS9_TAP_A] ^ lfsr_q[tps_pkg::PRBS9_TAP_B])
                       : (lfsr_q[tps_pkg::PRBS15_TAP_A] ^ lfsr_q[tps_pkg::PRBS15_TAP_B]);

  always_comb begin
    case (pat_q)
      tps_pkg::PAT_IDLE: pat_d = (transmit_cmd && (prbs9_on || prbs15_on))
                                 ? tps_pkg::PAT_RUN : tps_pkg::PAT_IDLE;
      tps_pkg::PAT_RUN:  pat_d = (prbs9_on || prbs15_on) ? tps_pkg::PAT_RUN : tps_pkg::PAT_IDLE;
      default:           pat_d = tps_pkg::PAT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pat_q          <= tps_pkg::PAT_IDLE;
      lfsr_q         <= tps_pkg::PRBS_SEED;
      prbs_tx_data   <= 1'b0;
      prbs_tx_active <= 1'b0;
    end else begin
      pat_q          <= pat_d;
      prbs_tx_active <= (pat_d == tps_pkg::PAT_RUN);
      if (pat_q == tps_pkg::PAT_IDLE) begin
        lfsr_q       <= tps_pkg::PRBS_SEED;
        prbs_tx_data <= 1'b0;
      end else if (tx_bit_tick) begin
        lfsr_q       <= {lfsr_q[13:0], fb};
        prbs_tx_data <= fb;
      end
    end
  end
endmodule

// ---- test/tps_test_page_checker.sv ----
/*
  Port-level checks of the test register page.
  Assumes binding to tps_test_page; one clock, synchronous reset.
*/
module tps_test_page_checker (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [tps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       transmit_cmd,
  input wire logic                       tx_bit_tick,
  input wire logic                       prbs_tx_active,
  input wire logic                       prbs_tx_data,
  input wire logic                       uart_aux_out_en,
  input wire logic                       uart_request_line_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RSVD_ZERO: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr[9:2]) == tps_pkg::IDX_RSVD |-> s_axi_rdata == 32'h0000_0000)
    else $error("reserved slot not zero");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_UART_PAIR: assert property (uart_aux_out_en == uart_request_line_en)
    else $error("uart enables differ");
  AST_UART_RESET: assert property ($rose(rst_n) |-> uart_aux_out_en)
    else $error("uart lines off after reset");
  AST_PRBS_START: assert property ($rose(prbs_tx_active) |-> $past(transmit_cmd))
    else $error("pattern started without command");
  AST_PRBS_TICK: assert property (prbs_tx_active && $past(prbs_tx_active) && $changed(prbs_tx_data) |-> $past(tx_bit_tick) || $past(tx_bit_tick, 2))
    else $error("pattern moved without tick");
endmodule
bind tps_test_page tps_test_page_checker i_tps_test_page_checker (.*);

// ---- test/tps_pin_probe.sv ----
/*
  Tester at the spare data pins: drives its own levels where the device
  does not drive. Assumes the device pin driver and enable as inputs.
*/
module tps_pin_probe (
  input  wire logic [6:1] pin_out,
  input  wire logic [6:1] pin_oe,
  input  wire logic [6:1] tester_level,
  output logic [6:1]      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins follow the tester
  assign pin_level = (pin_out & pin_oe) | (tester_level & ~pin_oe);
endmodule

// ---- test/tps_test_page_tb_top.sv ----
/*
  Self-checking bench of the test register page over AXI4-Lite.
  Assumes the checker bound to the design and the pin tester model.
*/
module tps_test_page_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic         clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic         s_axi_rready, serial_host_active, transmit_cmd, tx_bit_tick;
  logic [255:0] probe_groups;
  logic [6:1]   data_pin_in, data_pin_out, data_pin_oe, tst_lvl;
  logic         multipurpose_out_pin, aux_pin_one_out, aux_pin_one_oe, aux_pin_two_out;
  logic         aux_pin_two_oe, uart_aux_out_en, uart_request_line_en;
  logic         prbs_tx_data, prbs_tx_active;
  logic [7:0]   ix [5] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34};
  logic [7:0]   rv [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0]   wv [4] = '{8'h00, 8'h07, 8'hFF, 8'hFE};
  logic [7:0]   gs [3] = '{8'h00, 8'h05, 8'h1F};
  logic [7:0]   p;
  int           err_total, cmp_count;

  tps_test_page i_tps_test_page (.*);
  tps_pin_probe i_tps_pin_probe (.pin_out(data_pin_out), .pin_oe(data_pin_oe),
                                 .tester_level(tst_lvl), .pin_level(data_pin_in));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] pb(input int g);
    return 8'(g * 37 + 90);
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic a, w, k;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 1'h0;
    while (!k) begin
      @(negedge clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      k = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (k) s_axi_bready <= 1'h0;
    end
    chk(k, 1, "write stall");
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a, k;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    k = 1'h0;
    while (!k) begin
      @(negedge clk);
      a = s_axi_arvalid && s_axi_arready;
      k = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (a) s_axi_arvalid <= 1'h0;
      if (k) s_axi_rready <= 1'h0;
    end
    chk(k, 1, "read stall");
  endtask

  task automatic prbs(input logic [7:0] ctl, input int ta, input int tb2);
    logic [39:0] s;
    int i;
    int bad;
    wr(8'h32, ctl, rsp);
    settle;
    chk(prbs_tx_active, 0, "started by enable");
    @(posedge clk);
    transmit_cmd <= 1'h1;
    @(posedge clk);
    transmit_cmd <= 1'h0;
    settle;
    chk(prbs_tx_active, 1, "not started");
    bad = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      tx_bit_tick <= 1'h1;
      @(posedge clk);
      tx_bit_tick <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      s[i] = prbs_tx_data;
      if (i >= ta && s[i] !== (s[i-ta] ^ s[i-tb2])) bad++;
    end
    chk(bad, 0, "pattern recurrence");
    chk(s == 40'h00_0000_0000, 0, "pattern stuck");
    wr(8'h32, 8'h00, rsp);
    settle;
    chk(prbs_tx_active, 0, "not stopped");
  endtask

  initial begin
    #100us;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {serial_host_active, transmit_cmd, tx_bit_tick} = 3'h0;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1;
    tst_lvl = 6'h35;
    err_total = 0;
    cmp_count = 0;
    for (int g = 0; g < 32; g++) probe_groups[8*g +: 8] = pb(g);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      rdr(ix[i], rd, rsp);
      chk(rd, rv[i], "reset value");
    end
    chk({uart_aux_out_en, uart_request_line_en}, 2'h3, "uart reset");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ix[i], 8'hFF, rsp);
      rdr(ix[i], rd, rsp);
      chk(rd, wv[i], "reserved bits");
    end
    wr(8'h35, 8'hFF, rsp);
    chk(rsp, tps_pkg::RESP_OKAY, "readback write");
    wr(8'h3F, 8'h12, rsp);
    chk(rsp, tps_pkg::RESP_SLVERR, "unmapped write");
    rdr(8'h3F, rd, rsp);
    chk(rsp, tps_pkg::RESP_SLVERR, "unmapped read");
    chk(rd, 32'h0000_0000, "unmapped data");
    s_axi_wstrb <= 4'h0;
    wr(8'h31, 8'h05, rsp);
    s_axi_wstrb <= 4'h1;
    rdr(8'h31, rd, rsp);
    chk(rd, 8'h07, "lane off write");
    $display("test reserved done");
    wr(8'h38, 8'hFF, rsp);
    for (int i = 0; i < 3; i++) begin
      p = pb(gs[i]);
      wr(8'h32, gs[i], rsp);
      settle;
      rdr(8'h35, rd, rsp);
      chk(rd, p, "probe bus");
      chk({data_pin_oe, data_pin_out}, {6'h3F, p[6:1]}, "pins natural");
      for (int b = 0; b < 8; b++) begin
        wr(8'h31, 8'(b), rsp);
        settle;
        chk(multipurpose_out_pin, p[b], "mf pin");
        chk({aux_pin_one_out, aux_pin_one_oe, aux_pin_two_out, aux_pin_two_oe},
            {p[b], 1'h1, p[b], 1'h1}, "aux pins");
      end
      wr(8'h32, 8'h80 | gs[i], rsp);
      settle;
      chk(data_pin_out, {p[0], p[5], p[6], p[2], p[3], p[4]}, "pins swapped");
    end
    wr(8'h38, 8'h00, rsp);
    settle;
    chk({aux_pin_one_oe, aux_pin_two_oe}, 2'h0, "aux off");
    wr(8'h38, 8'hAB, rsp);
    settle;
    chk({aux_pin_one_out, aux_pin_one_oe, aux_pin_two_out, aux_pin_two_oe}, 4'hD, "aux fixed");
    $display("test bus done");
    wr(8'h33, 8'h00, rsp);
    settle;
    chk({uart_aux_out_en, uart_request_line_en, data_pin_oe}, 8'h00, "uart off");
    @(posedge clk);
    serial_host_active <= 1'h1;
    wr(8'h33, 8'h9E, rsp);
    wr(8'h34, 8'hD4, rsp);
    settle;
    chk({uart_aux_out_en, data_pin_oe}, 7'h4F, "io enables");
    chk(data_pin_out[4:1], 4'hA, "io levels");
    rdr(8'h34, rd, rsp);
    chk(rd, {1'h1, (6'h2A & 6'h0F) | (tst_lvl & 6'h30), 1'h0}, "live pins");
    wr(8'h34, 8'h54, rsp);
    rdr(8'h34, rd, rsp);
    chk(rd, 8'h54, "stored pins");
    $display("test io done");
    prbs(8'h40, 9, 5);
    prbs(8'h20, 15, 14);
    prbs(8'h60, 9, 5);
    $display("test pattern done");
    give_verdict;
  end
endmodule
